// *** verilog/irq_ctrl_pkg.sv ***
// constants, register map and carrier types of the interrupt control block
package irq_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FLAGCTL = 8'h88;
   localparam logic [7:0] IDX_IE = 8'hA8;
   localparam logic [7:0] IDX_EN2 = 8'hA9;
   localparam logic [7:0] IDX_PRIO2 = 8'hB9;
   localparam logic [7:0] IDX_G0F = 8'hBA;
   localparam logic [7:0] IDX_G0R = 8'hBB;
   localparam logic [7:0] IDX_G1F = 8'hBC;
   localparam logic [7:0] IDX_G1R = 8'hBD;
   localparam logic [7:0] IDX_G2F = 8'hC6;
   localparam logic [7:0] IDX_G2R = 8'hC7;
   // field positions
   localparam int BIT_GALLOW = 7;
   localparam int BIT_TOUCH = 4;
   localparam int BIT_EXT2 = 3;
   localparam int BIT_BTM = 2;
   localparam int BIT_PWM = 1;
   localparam int BIT_SER = 0;
   localparam int BIT_FLAG1 = 3;
   localparam int BIT_FLAG0 = 1;
   // writable masks; reserved positions read as zero
   localparam logic [7:0] MASK_IE = 8'h80;
   localparam logic [7:0] MASK_EN2 = 8'h1F;
   localparam logic [7:0] MASK_FLAGCTL = 8'h0A;
   localparam logic [7:0] MASK_G0 = 8'h0E;
   localparam logic [7:0] MASK_G1 = 8'h0F;
   localparam logic [7:0] MASK_G2 = 8'h3F;
   localparam logic [7:0] RST_REG = 8'h00;
   // arbitration slots, lowest slot has the smallest query number
   localparam int NSRC = 7;
   localparam int S_EXT0 = 0;
   localparam int S_EXT1 = 1;
   localparam int S_SER = 2;
   localparam int S_PWM = 3;
   localparam int S_TOUCH = 4;
   localparam int S_EXT2 = 5;
   localparam int S_BTM = 6;
   localparam logic [3:0] Q_EXT0 = 4'h0;
   localparam logic [3:0] Q_EXT1 = 4'h2;
   localparam logic [3:0] Q_SER = 4'h7;
   localparam logic [3:0] Q_PWM = 4'h8;
   localparam logic [3:0] Q_TOUCH = 4'h9;
   localparam logic [3:0] Q_EXT2 = 4'hA;
   localparam logic [3:0] Q_BTM = 4'hB;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] idx;
   } addr_phase_t;

   typedef struct packed {
      logic valid;
      logic high;
      logic [3:0] qnum;
   } irq_req_t;
endpackage : irq_ctrl_pkg

// *** verilog/irq_enable_priority_edge_ctrl.sv ***
// interrupt enable, priority, arbitration and external edge detection
//
// Summary of operation
// [R1] enable bit 4 gates touch interrupt
// [R2] enable bit 3 gates external group 2
// [R3] enable bit 2 gates base timer
// [R4] enable bit 1 gates pwm overflow
// [R5] enable bit 0 gates serial port
// [R6] priority bit 4 lifts touch high
// [R7] priority bit 3 lifts group 2 high
// [R8] priority bit 2 lifts base timer high
// [R9] priority bit 1 lifts pwm high
// [R10] priority bit 0 lifts serial port high
// [R11] group 1 flag set, cleared on response
// [R12] group 0 flag set, cleared on response
// [R13] group 0 falling-edge selects, bits 3..1
// [R14] group 0 rising-edge selects, bits 3..1
// [R15] group 1 falling-edge selects, bits 3..0
// [R16] group 1 rising-edge selects, bits 3..0
// [R17] group 2 falling-edge selects, bits 5..0
// [R18] group 2 rising-edge selects, bits 5..0
// [R19] both selects: either edge; edges wake
// [R20] global allow gates every source
// [R21] high preempts low, never same level
// [R22] same level: smallest query number first
// [R23] all control bits reset to zero
// [R24] reserved bits ignore writes, read zero
`timescale 1ns/1ps
module irq_enable_priority_edge_ctrl #(
   parameter int NA = 3,
   parameter int NB = 4,
   parameter int NC = 6
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // external pins, asynchronous
   input wire logic [NA:1] ext_irq_group_a,
   input wire logic [NB-1:0] ext_irq_group_b,
   input wire logic [NC-1:0] ext_irq_group_c,
   // peripheral requests, same clock, held until cleared by their owner
   input wire logic touch_req,
   input wire logic base_timer_req,
   input wire logic pwm_req,
   input wire logic serial_req,
   // processor core
   input wire logic irq_ack,
   input wire logic [3:0] irq_ack_qnum,
   input wire logic irq_reti,
   output logic irq_valid,
   output logic irq_high,
   output logic [3:0] irq_qnum,
   output logic stop_wake
);

   // registers
   logic global_irq_allow_r;
   logic [7:0] en2_r;
   logic [7:0] prio2_r;
   logic ext_group0_request_flag_r;
   logic ext_group1_request_flag_r;
   logic ext_group2_pend_r;
   logic [NA:1] group0_fall_select_r;
   logic [NA:1] group0_rise_select_r;
   logic [NB-1:0] group1_fall_select_r;
   logic [NB-1:0] group1_rise_select_r;
   logic [NC-1:0] group2_fall_select_r;
   logic [NC-1:0] group2_rise_select_r;
   logic in_high_r;
   logic in_low_r;
   irq_ctrl_pkg::addr_phase_t aph_r;
   irq_ctrl_pkg::irq_req_t req_r;
   logic wake_r;
   logic [31:0] rdata_r;

   // synchronisers
   logic [NA:1] a_s1_r, a_s2_r, a_old_r;
   logic [NB-1:0] b_s1_r, b_s2_r, b_old_r;
   logic [NC-1:0] c_s1_r, c_s2_r, c_old_r;

   function automatic logic edge_hit(input logic [7:0] old_v, input logic [7:0] cur_v,
                                     input logic [7:0] rise, input logic [7:0] fall);
      edge_hit = |((~old_v & cur_v & rise) | (old_v & ~cur_v & fall));
   endfunction : edge_hit

   function automatic logic [3:0] slot_qnum(input logic [2:0] slot);
      case (slot)
         3'd0: slot_qnum = irq_ctrl_pkg::Q_EXT0;
         3'd1: slot_qnum = irq_ctrl_pkg::Q_EXT1;
         3'd2: slot_qnum = irq_ctrl_pkg::Q_SER;
         3'd3: slot_qnum = irq_ctrl_pkg::Q_PWM;
         3'd4: slot_qnum = irq_ctrl_pkg::Q_TOUCH;
         3'd5: slot_qnum = irq_ctrl_pkg::Q_EXT2;
         default: slot_qnum = irq_ctrl_pkg::Q_BTM;
      endcase
   endfunction : slot_qnum

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_s1_r <= '0;
         a_s2_r <= '0;
         a_old_r <= '0;
         b_s1_r <= '0;
         b_s2_r <= '0;
         b_old_r <= '0;
         c_s1_r <= '0;
         c_s2_r <= '0;
         c_old_r <= '0;
      end else begin
         a_s1_r <= ext_irq_group_a;
         a_s2_r <= a_s1_r;
         a_old_r <= a_s2_r;
         b_s1_r <= ext_irq_group_b;
         b_s2_r <= b_s1_r;
         b_old_r <= b_s2_r;
         c_s1_r <= ext_irq_group_c;
         c_s2_r <= c_s1_r;
         c_old_r <= c_s2_r;
      end
   end

   // edge detection; the first synchroniser stage is never looked at
   logic hit0, hit1, hit2;
   always_comb begin
      hit0 = edge_hit(8'({a_old_r, 1'b0}), 8'({a_s2_r, 1'b0}),
                      8'({group0_rise_select_r, 1'b0}),
                      8'({group0_fall_select_r, 1'b0})); // [R13] [R14] [R19]
      hit1 = edge_hit(8'(b_old_r), 8'(b_s2_r), 8'(group1_rise_select_r),
                      8'(group1_fall_select_r)); // [R15] [R16] [R19]
      hit2 = edge_hit(8'(c_old_r), 8'(c_s2_r), 8'(group2_rise_select_r),
                      8'(group2_fall_select_r)); // [R17] [R18] [R19]
   end

   // bus decode
   logic take;
   logic wr_en;
   logic [7:0] wd;
   always_comb begin
      take = hsel && hready && htrans == irq_ctrl_pkg::HTRANS_NONSEQ;
      wr_en = aph_r.valid && aph_r.write;
      wd = hwdata[7:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_r <= '0;
      end else if (hready) begin
         aph_r.valid <= take;
         aph_r.write <= hwrite;
         aph_r.idx <= haddr[9:2];
      end
   end

   // software writable control; reserved bits are never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_irq_allow_r <= 1'b0; // [R23]
         en2_r <= irq_ctrl_pkg::RST_REG;
         prio2_r <= irq_ctrl_pkg::RST_REG;
         group0_fall_select_r <= '0;
         group0_rise_select_r <= '0;
         group1_fall_select_r <= '0;
         group1_rise_select_r <= '0;
         group2_fall_select_r <= '0;
         group2_rise_select_r <= '0;
      end else if (wr_en) begin
         case (aph_r.idx)
            irq_ctrl_pkg::IDX_IE: global_irq_allow_r <= wd[irq_ctrl_pkg::BIT_GALLOW];
            irq_ctrl_pkg::IDX_EN2: en2_r <= wd & irq_ctrl_pkg::MASK_EN2; // [R24]
            irq_ctrl_pkg::IDX_PRIO2: prio2_r <= wd & irq_ctrl_pkg::MASK_EN2; // [R24]
            irq_ctrl_pkg::IDX_G0F: group0_fall_select_r <= wd[NA:1]; // [R13]
            irq_ctrl_pkg::IDX_G0R: group0_rise_select_r <= wd[NA:1]; // [R14]
            irq_ctrl_pkg::IDX_G1F: group1_fall_select_r <= wd[NB-1:0]; // [R15]
            irq_ctrl_pkg::IDX_G1R: group1_rise_select_r <= wd[NB-1:0]; // [R16]
            irq_ctrl_pkg::IDX_G2F: group2_fall_select_r <= wd[NC-1:0]; // [R17]
            irq_ctrl_pkg::IDX_G2R: group2_rise_select_r <= wd[NC-1:0]; // [R18]
            default: ;
         endcase
      end
   end

   // hardware flags; a new edge wins over the acknowledge or a software clear
   logic ack0, ack1, ack2, sw_flagctl;
   always_comb begin
      ack0 = irq_ack && irq_ack_qnum == irq_ctrl_pkg::Q_EXT0;
      ack1 = irq_ack && irq_ack_qnum == irq_ctrl_pkg::Q_EXT1;
      ack2 = irq_ack && irq_ack_qnum == irq_ctrl_pkg::Q_EXT2;
      sw_flagctl = wr_en && aph_r.idx == irq_ctrl_pkg::IDX_FLAGCTL;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_group0_request_flag_r <= 1'b0;
      end else if (hit0) begin
         ext_group0_request_flag_r <= 1'b1; // [R12]
      end else if (sw_flagctl) begin
         ext_group0_request_flag_r <= wd[irq_ctrl_pkg::BIT_FLAG0];
      end else if (ack0) begin
         ext_group0_request_flag_r <= 1'b0; // [R12]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_group1_request_flag_r <= 1'b0;
      end else if (hit1) begin
         ext_group1_request_flag_r <= 1'b1; // [R11]
      end else if (sw_flagctl) begin
         ext_group1_request_flag_r <= wd[irq_ctrl_pkg::BIT_FLAG1];
      end else if (ack1) begin
         ext_group1_request_flag_r <= 1'b0; // [R11]
      end
   end

   // group 2 has no visible flag; its request is held until responded to
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_group2_pend_r <= 1'b0;
      end else if (hit2) begin
         ext_group2_pend_r <= 1'b1;
      end else if (ack2) begin
         ext_group2_pend_r <= 1'b0;
      end
   end

   // stop-mode wake does not depend on the enables or the global allow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= hit0 || hit1 || hit2; // [R19]
      end
   end

   // pending and level of each slot
   logic [irq_ctrl_pkg::NSRC-1:0] pend;
   logic [irq_ctrl_pkg::NSRC-1:0] lvl;
   always_comb begin
      pend = '0;
      lvl = '0;
      pend[irq_ctrl_pkg::S_EXT0] = ext_group0_request_flag_r;
      pend[irq_ctrl_pkg::S_EXT1] = ext_group1_request_flag_r;
      pend[irq_ctrl_pkg::S_TOUCH] = touch_req && en2_r[irq_ctrl_pkg::BIT_TOUCH]; // [R1]
      pend[irq_ctrl_pkg::S_EXT2] = ext_group2_pend_r && en2_r[irq_ctrl_pkg::BIT_EXT2]; // [R2]
      pend[irq_ctrl_pkg::S_BTM] = base_timer_req && en2_r[irq_ctrl_pkg::BIT_BTM]; // [R3]
      pend[irq_ctrl_pkg::S_PWM] = pwm_req && en2_r[irq_ctrl_pkg::BIT_PWM]; // [R4]
      pend[irq_ctrl_pkg::S_SER] = serial_req && en2_r[irq_ctrl_pkg::BIT_SER]; // [R5]
      lvl[irq_ctrl_pkg::S_TOUCH] = prio2_r[irq_ctrl_pkg::BIT_TOUCH]; // [R6]
      lvl[irq_ctrl_pkg::S_EXT2] = prio2_r[irq_ctrl_pkg::BIT_EXT2]; // [R7]
      lvl[irq_ctrl_pkg::S_BTM] = prio2_r[irq_ctrl_pkg::BIT_BTM]; // [R8]
      lvl[irq_ctrl_pkg::S_PWM] = prio2_r[irq_ctrl_pkg::BIT_PWM]; // [R9]
      lvl[irq_ctrl_pkg::S_SER] = prio2_r[irq_ctrl_pkg::BIT_SER]; // [R10]
   end

   // two-level arbitration; the first-level registers live outside this
   // block, so the group 0 and 1 sources are always enabled at low level
   logic [irq_ctrl_pkg::NSRC-1:0] cand_hi, cand_lo;
   logic pick_v, pick_h;
   logic [2:0] pick_s;
   always_comb begin
      cand_hi = pend & lvl;
      cand_lo = pend & ~lvl;
      pick_v = 1'b0;
      pick_h = 1'b0;
      pick_s = 3'd0;
      if (global_irq_allow_r && !in_high_r) begin // [R20] [R21]
         for (int i = irq_ctrl_pkg::NSRC - 1; i >= 0; i--) begin
            if (cand_hi[i]) begin
               pick_v = 1'b1;
               pick_h = 1'b1;
               pick_s = 3'(i); // [R22]
            end
         end
         if (!pick_v && !in_low_r) begin // [R21]
            for (int i = irq_ctrl_pkg::NSRC - 1; i >= 0; i--) begin
               if (cand_lo[i]) begin
                  pick_v = 1'b1;
                  pick_s = 3'(i); // [R22]
               end
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r <= '0;
      end else begin
         req_r.valid <= pick_v && !irq_ack;
         req_r.high <= pick_h;
         req_r.qnum <= slot_qnum(pick_s);
      end
   end

   // in-service levels; the acknowledge is trusted to name the offered request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_high_r <= 1'b0;
         in_low_r <= 1'b0;
      end else if (irq_ack) begin
         if (req_r.high) begin
            in_high_r <= 1'b1; // [R21]
         end else begin
            in_low_r <= 1'b1;
         end
      end else if (irq_reti) begin
         if (in_high_r) begin
            in_high_r <= 1'b0;
         end else begin
            in_low_r <= 1'b0;
         end
      end
   end

   // read data registered in the address phase, shown in the data phase
   logic [7:0] rd;
   always_comb begin
      rd = 8'h00;
      case (haddr[9:2])
         irq_ctrl_pkg::IDX_IE: rd = {global_irq_allow_r, 7'h00};
         irq_ctrl_pkg::IDX_EN2: rd = en2_r;
         irq_ctrl_pkg::IDX_PRIO2: rd = prio2_r;
         irq_ctrl_pkg::IDX_FLAGCTL: rd = {4'h0, ext_group1_request_flag_r, 1'b0,
                                       ext_group0_request_flag_r, 1'b0}; // [R24]
         irq_ctrl_pkg::IDX_G0F: rd = 8'({group0_fall_select_r, 1'b0});
         irq_ctrl_pkg::IDX_G0R: rd = 8'({group0_rise_select_r, 1'b0});
         irq_ctrl_pkg::IDX_G1F: rd = 8'(group1_fall_select_r);
         irq_ctrl_pkg::IDX_G1R: rd = 8'(group1_rise_select_r);
         irq_ctrl_pkg::IDX_G2F: rd = 8'(group2_fall_select_r);
         irq_ctrl_pkg::IDX_G2R: rd = 8'(group2_rise_select_r);
         default: rd = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 32'h00000000;
      end else if (take && !hwrite) begin
         rdata_r <= {24'h000000, rd};
      end
   end

   always_comb begin
      hrdata = rdata_r;
      hreadyout = 1'b1;
      hresp = 1'b0;
      irq_valid = req_r.valid;
      irq_high = req_r.high;
      irq_qnum = req_r.qnum;
      stop_wake = wake_r;
   end

   // checks
   a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid |-> $past(global_irq_allow_r)) // [R20]
      else $error("request offered while global allow was off");
   a_touch_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid && irq_qnum == irq_ctrl_pkg::Q_TOUCH |-> $past(en2_r[4]) && $past(touch_req)) // [R1]
      else $error("touch request offered while blocked");
   a_ext2_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid && irq_qnum == irq_ctrl_pkg::Q_EXT2 |-> $past(en2_r[3])) // [R2]
      else $error("group 2 request offered while blocked");
   a_pwm_level: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid && irq_qnum == irq_ctrl_pkg::Q_PWM |-> irq_high == $past(prio2_r[1])) // [R9]
      else $error("pwm request at wrong level");
   a_no_same_nest: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid |-> !$past(in_high_r) && ($past(in_low_r) -> irq_high)) // [R21]
      else $error("request offered at a level already in service");
   a_flag0_set: assert property (@(posedge hclk) disable iff (!hresetn)
      hit0 |=> ext_group0_request_flag_r) // [R12]
      else $error("group 0 edge did not set its flag");
   a_flag1_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      ack1 && !hit1 && !sw_flagctl |=> !ext_group1_request_flag_r) // [R11]
      else $error("group 1 flag not cleared on response");
   a_wake_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(c_s2_r[NC-1]) && group2_rise_select_r[NC-1]
      |=> stop_wake) // [R18]
      else $error("group 2 rising edge missed");
   a_order_low: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid && irq_qnum == irq_ctrl_pkg::Q_EXT1 && !irq_high
      |-> !$past(ext_group0_request_flag_r)) // [R22]
      else $error("larger query number served before smaller");
   a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      en2_r[7:5] == 3'h0 && prio2_r[7:5] == 3'h0) // [R24]
      else $error("reserved enable or priority bits set");

endmodule : irq_enable_priority_edge_ctrl

// *** test/core_model.sv ***
// processor core stand-in: takes offered interrupts and returns from handlers
`timescale 1ns/1ps
module core_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // offer from the controller
   input wire logic irq_valid,
   input wire logic [3:0] irq_qnum,
   // bench control
   input wire logic ack_en,
   input wire logic [3:0] ack_delay,
   input wire logic reti_go,
   // answer to the controller
   output logic irq_ack,
   output logic [3:0] irq_ack_qnum,
   output logic irq_reti,
   output int ack_cnt
);
   logic [3:0] lag_r;
   logic go;
   assign go = ack_en && irq_valid && !irq_ack;
   // an offer that vanishes while waiting restarts the lag, so no stale ack leaves
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ack <= 1'b0;
         irq_ack_qnum <= 4'h0;
         lag_r <= 4'h0;
         ack_cnt <= 0;
      end else if (go && lag_r == ack_delay) begin
         irq_ack <= 1'b1;
         irq_ack_qnum <= irq_qnum;
         lag_r <= 4'h0;
         ack_cnt <= ack_cnt + 1;
      end else begin
         irq_ack <= 1'b0;
         // number is meaningless outside the pulse, so it keeps moving
         irq_ack_qnum <= ~irq_ack_qnum;
         lag_r <= go ? lag_r + 4'h1 : 4'h0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_reti <= 1'b0;
      end else begin
         irq_reti <= reti_go;
      end
   end
endmodule : core_model

// *** test/tb.sv ***
// self-checking bench for the interrupt enable, priority and edge block
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] RIDX [10] = '{irq_ctrl_pkg::IDX_EN2, irq_ctrl_pkg::IDX_PRIO2,
      irq_ctrl_pkg::IDX_G0F, irq_ctrl_pkg::IDX_G0R, irq_ctrl_pkg::IDX_G1F,
      irq_ctrl_pkg::IDX_G1R, irq_ctrl_pkg::IDX_G2F, irq_ctrl_pkg::IDX_G2R,
      irq_ctrl_pkg::IDX_FLAGCTL, irq_ctrl_pkg::IDX_IE};
   localparam logic [7:0] RMSK [10] = '{irq_ctrl_pkg::MASK_EN2, irq_ctrl_pkg::MASK_EN2,
      irq_ctrl_pkg::MASK_G0, irq_ctrl_pkg::MASK_G0, irq_ctrl_pkg::MASK_G1,
      irq_ctrl_pkg::MASK_G1, irq_ctrl_pkg::MASK_G2, irq_ctrl_pkg::MASK_G2,
      irq_ctrl_pkg::MASK_FLAGCTL, irq_ctrl_pkg::MASK_IE};
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:1] pin_a;
   logic [3:0] pin_b;
   logic [5:0] pin_c;
   logic [4:0] preq;
   logic irq_ack;
   logic [3:0] irq_ack_qnum;
   logic irq_reti;
   logic irq_valid;
   logic irq_high;
   logic [3:0] irq_qnum;
   logic stop_wake;
   logic ack_en;
   logic [3:0] ack_delay;
   logic reti_go;
   int ack_cnt;
   int n_errors = 0;
   int n_tests = 0;
   int n_wake = 0;
   logic [31:0] rd;

   irq_enable_priority_edge_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_irq_group_a(pin_a), .ext_irq_group_b(pin_b), .ext_irq_group_c(pin_c),
      .touch_req(preq[4]), .base_timer_req(preq[2]), .pwm_req(preq[1]),
      .serial_req(preq[0]), .irq_ack(irq_ack), .irq_ack_qnum(irq_ack_qnum),
      .irq_reti(irq_reti), .irq_valid(irq_valid), .irq_high(irq_high),
      .irq_qnum(irq_qnum), .stop_wake(stop_wake));
   core_model u_core (.hclk(hclk), .hresetn(hresetn), .irq_valid(irq_valid),
      .irq_qnum(irq_qnum), .ack_en(ack_en), .ack_delay(ack_delay), .reti_go(reti_go),
      .irq_ack(irq_ack), .irq_ack_qnum(irq_ack_qnum), .irq_reti(irq_reti),
      .ack_cnt(ack_cnt));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (stop_wake === 1'b1) begin
         n_wake++;
      end
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= irq_ctrl_pkg::HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk({31'h0, hresp}, 32'h0);
   endtask : rdc
   // waits for the exact offer, so a late but correct change of choice still passes
   task automatic offer(input logic [3:0] q, input logic h);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while ({irq_valid, irq_high, irq_qnum} !== {1'b1, h, q} && n < 30);
      chk({26'h0, irq_valid, irq_high, irq_qnum}, {26'h0, 1'b1, h, q});
      if ({irq_valid, irq_high, irq_qnum} !== {1'b1, h, q}) begin
         tally_and_finish();
      end
   endtask : offer
   task automatic none();
      repeat (8) @(posedge hclk);
      chk({31'h0, irq_valid}, 32'h0);
   endtask : none
   task automatic take(input logic [3:0] lag);
      int c0;
      int n;
      c0 = ack_cnt;
      n = 0;
      ack_delay <= lag;
      ack_en <= 1'b1;
      do begin
         @(posedge hclk);
         n++;
      end while (ack_cnt == c0 && n < 30);
      ack_en <= 1'b0;
      @(posedge hclk);
      if (ack_cnt == c0) begin
         n_errors++;
         tally_and_finish();
      end
   endtask : take
   task automatic reti();
      reti_go <= 1'b1;
      @(posedge hclk);
      reti_go <= 1'b0;
      @(posedge hclk);
   endtask : reti
   task automatic hit(input logic [3:0] q, input logic h, input logic [7:0] tf);
      offer(q, h);
      rdc(irq_ctrl_pkg::IDX_FLAGCTL, tf);
      take(4'h2);
      rdc(irq_ctrl_pkg::IDX_FLAGCTL, 8'h00);
      reti();
   endtask : hit
   function automatic logic [3:0] qof(input int i);
      case (i)
         0: return irq_ctrl_pkg::Q_SER;
         1: return irq_ctrl_pkg::Q_PWM;
         2: return irq_ctrl_pkg::Q_BTM;
         default: return irq_ctrl_pkg::Q_TOUCH;
      endcase
   endfunction : qof

   task automatic s_regs();
      chk({31'h0, irq_valid}, 32'h0);
      rdc(8'h00, 8'h00);
      for (int i = 0; i < 10; i++) begin
         rdc(RIDX[i], 8'h00);
      end
      // global allow written last so the flag bits never see it open
      for (int i = 0; i < 10; i++) begin
         wr(RIDX[i], 8'hFF);
         rdc(RIDX[i], RMSK[i]);
         wr(RIDX[i], 8'h00);
      end
      wr(8'h00, 8'hFF);
      rdc(8'h00, 8'h00);
   endtask : s_regs
   task automatic s_enable();
      wr(irq_ctrl_pkg::IDX_IE, 8'h80);
      for (int i = 0; i < 5; i++) begin
         if (i != 3) begin
            preq <= 5'(1 << i);
            none();
            wr(irq_ctrl_pkg::IDX_EN2, 8'(1 << i));
            offer(qof(i), 1'b0);
            wr(irq_ctrl_pkg::IDX_IE, 8'h00);
            none();
            wr(irq_ctrl_pkg::IDX_IE, 8'h80);
            take(4'(i));
            none();
            preq <= 5'h00;
            reti();
            wr(irq_ctrl_pkg::IDX_EN2, 8'h00);
         end
      end
   endtask : s_enable
   task automatic s_prio();
      wr(irq_ctrl_pkg::IDX_EN2, 8'h17);
      preq <= 5'h17;
      offer(irq_ctrl_pkg::Q_SER, 1'b0);
      for (int i = 0; i < 5; i++) begin
         if (i != 3) begin
            wr(irq_ctrl_pkg::IDX_PRIO2, 8'(1 << i));
            offer(qof(i), 1'b1);
         end
      end
      wr(irq_ctrl_pkg::IDX_PRIO2, 8'h00);
      offer(irq_ctrl_pkg::Q_SER, 1'b0);
      take(4'h1);
      none();
      wr(irq_ctrl_pkg::IDX_PRIO2, 8'h10);
      offer(irq_ctrl_pkg::Q_TOUCH, 1'b1);
      take(4'h0);
      wr(irq_ctrl_pkg::IDX_PRIO2, 8'h1F);
      none();
      reti();
      offer(irq_ctrl_pkg::Q_SER, 1'b1);
      preq <= 5'h00;
      wr(irq_ctrl_pkg::IDX_PRIO2, 8'h00);
      reti();
   endtask : s_prio
   task automatic s_edges();
      int w0;
      w0 = n_wake;
      wr(irq_ctrl_pkg::IDX_G0F, 8'h02);
      pin_a[1] <= 1'b0;
      hit(irq_ctrl_pkg::Q_EXT0, 1'b0, 8'h02);
      chk(32'(n_wake - w0), 32'h1);
      wr(irq_ctrl_pkg::IDX_G0R, 8'h04);
      pin_a[2] <= 1'b0;
      none();
      pin_a[2] <= 1'b1;
      hit(irq_ctrl_pkg::Q_EXT0, 1'b0, 8'h02);
      wr(irq_ctrl_pkg::IDX_G1R, 8'h01);
      pin_b[0] <= 1'b1;
      hit(irq_ctrl_pkg::Q_EXT1, 1'b0, 8'h08);
      wr(irq_ctrl_pkg::IDX_G1F, 8'h08);
      pin_b[3] <= 1'b1;
      none();
      pin_b[3] <= 1'b0;
      hit(irq_ctrl_pkg::Q_EXT1, 1'b0, 8'h08);
      wr(irq_ctrl_pkg::IDX_EN2, 8'h08);
      wr(irq_ctrl_pkg::IDX_G2F, 8'h20);
      wr(irq_ctrl_pkg::IDX_G2R, 8'h20);
      pin_c[5] <= 1'b1;
      hit(irq_ctrl_pkg::Q_EXT2, 1'b0, 8'h00);
      wr(irq_ctrl_pkg::IDX_PRIO2, 8'h08);
      pin_c[5] <= 1'b0;
      hit(irq_ctrl_pkg::Q_EXT2, 1'b1, 8'h00);
   endtask : s_edges

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pin_a = 3'h7;
      pin_b = 4'h0;
      pin_c = 6'h00;
      preq = 5'h00;
      ack_en = 1'b0;
      ack_delay = 4'h0;
      reti_go = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      s_regs();
      s_enable();
      s_prio();
      s_edges();
      tally_and_finish();
   end
endmodule : tb
